// ==== bench/iecm_host_model.sv ====
`timescale 1ns/10ps
// ==========================================================================
// host: spi mode 0 master and board side of both irq lines
module iecm_host_model (
  input  wire clk,
  input  wire spi_sdo_o,
  input  wire spi_sdo_oe_n,
  input  wire pri_o,
  input  wire pri_oe_n,
  input  wire sec_o,
  input  wire sec_oe_n,
  output reg  spi_csb_n,
  output reg  spi_sclk,
  output reg  spi_sdi,
  output wire pri_level,
  output wire sec_level
);
  // board pull-ups make each line a wired-or of low drivers
  assign pri_level = pri_oe_n ? 1'b1 : pri_o;
  assign sec_level = sec_oe_n ? 1'b1 : sec_o;

  initial begin
    spi_csb_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi = 1'b0;
  end

  // one 32-bit frame, sclk stays low outside it; sdo sampled before each of the last 24 rises
  task automatic xfer(input [6:0] a, input rw, input [23:0] wd, output [23:0] rdat);
    reg [31:0] f;
    integer    i;
    f = {a, rw, wd};
    rdat = 24'h0;
    @(negedge clk);
    spi_csb_n = 1'b0;
    repeat (8) @(negedge clk);
    for (i = 31; i >= 0; i = i - 1) begin
      spi_sdi = f[i];
      repeat (8) @(negedge clk);
      if (i < 24) begin
        rdat = {rdat[22:0], spi_sdo_oe_n ? 1'bx : spi_sdo_o};
      end
      spi_sclk = 1'b1;
      repeat (8) @(negedge clk);
      spi_sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    spi_csb_n = 1'b1;
    spi_sdi = ~f[0];
    repeat (8) @(negedge clk);
  endtask
endmodule

// ==== bench/iecm_properties.sv ====
`timescale 1ns/10ps
// ==========================================================================
// port checker for the interrupt manager
module iecm_properties #(
  parameter [31:0] LOFF_CYC = 32'h00000014
) (
  input wire clk,
  input wire sys_rst,
  input wire spi_csb_n,
  input wire spi_sclk,
  input wire spi_sdo_o,
  input wire spi_sdo_oe_n,
  input wire primary_irq_pin_o,
  input wire primary_irq_pin_oe_n,
  input wire primary_irq_pin_pullup_en,
  input wire secondary_irq_pin_o,
  input wire secondary_irq_pin_oe_n,
  input wire secondary_irq_pin_pullup_en
);
  // ==========================================================================
  // no spi frame seen since reset
  reg untouched_q;
  always @(posedge clk) begin
    untouched_q <= sys_rst | (untouched_q & spi_csb_n);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // assertions
  chk_rst_pri_idle: assert property ($fell(sys_rst) |->
    primary_irq_pin_oe_n && primary_irq_pin_pullup_en) else $error("primary pin not idle");
  chk_rst_sec_idle: assert property ($fell(sys_rst) |->
    secondary_irq_pin_oe_n && secondary_irq_pin_pullup_en) else $error("secondary pin not idle");
  chk_quiet_pri_pin: assert property (untouched_q |-> primary_irq_pin_oe_n)
    else $error("primary pin active with no enables");
  chk_quiet_sec_pin: assert property (untouched_q |-> secondary_irq_pin_oe_n)
    else $error("secondary pin active with no enables");
  chk_od_pri_low: assert property (primary_irq_pin_pullup_en |-> !primary_irq_pin_o)
    else $error("primary open drain drives high");
  chk_od_sec_low: assert property (secondary_irq_pin_pullup_en |-> !secondary_irq_pin_o)
    else $error("secondary open drain drives high");
  chk_sdo_idle_release: assert property (spi_csb_n [*6] |-> spi_sdo_oe_n)
    else $error("sdo driven while deselected");
  chk_sdo_bit_hold: assert property ((!spi_csb_n && spi_sclk) [*6] |-> $stable(spi_sdo_o))
    else $error("sdo changed while sclk high");
endmodule

bind iecm_core iecm_properties #(.LOFF_CYC(LOFF_CYC)) u_props (
  .clk(clk), .sys_rst(sys_rst), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
  .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_n(spi_sdo_oe_n),
  .primary_irq_pin_o(primary_irq_pin_o), .primary_irq_pin_oe_n(primary_irq_pin_oe_n),
  .primary_irq_pin_pullup_en(primary_irq_pin_pullup_en),
  .secondary_irq_pin_o(secondary_irq_pin_o), .secondary_irq_pin_oe_n(secondary_irq_pin_oe_n),
  .secondary_irq_pin_pullup_en(secondary_irq_pin_pullup_en));

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`include "iecm_consts.vh"
// ==========================================================================
// testbench
module tb;
  reg        clk = 1'b0;
  reg        sys_rst = 1'b1;
  reg        recovery_engaged = 1'b0;
  reg        lead_off_cond = 1'b0;
  reg        lead_on_cond = 1'b0;
  reg        loop_unlocked = 1'b0;
  reg        beat_event = 1'b0;
  reg        sample_instant = 1'b0;
  wire       csb_n, sclk, sdi, sdo_o, sdo_oe_n;
  wire       p_o, p_oe_n, p_pu, p_lvl, s_o, s_oe_n, s_pu, s_lvl;
  integer    n_errors = 0;
  integer    checks = 0;
  reg [23:0] d;
  reg [23:0] n;
  integer    s, t, seen;

  always #25 clk = ~clk;

  iecm_core #(.LOFF_CYC(32'h00000014)) dut (
    .clk(clk), .sys_rst(sys_rst), .spi_csb_n(csb_n), .spi_sclk(sclk), .spi_sdi(sdi),
    .spi_sdo_o(sdo_o), .spi_sdo_oe_n(sdo_oe_n), .recovery_engaged(recovery_engaged),
    .lead_off_cond(lead_off_cond), .lead_on_cond(lead_on_cond),
    .loop_unlocked(loop_unlocked), .beat_event(beat_event), .sample_instant(sample_instant),
    .primary_irq_pin_o(p_o), .primary_irq_pin_oe_n(p_oe_n), .primary_irq_pin_pullup_en(p_pu),
    .secondary_irq_pin_o(s_o), .secondary_irq_pin_oe_n(s_oe_n),
    .secondary_irq_pin_pullup_en(s_pu));

  iecm_host_model host (
    .clk(clk), .spi_sdo_o(sdo_o), .spi_sdo_oe_n(sdo_oe_n), .pri_o(p_o), .pri_oe_n(p_oe_n),
    .sec_o(s_o), .sec_oe_n(s_oe_n), .spi_csb_n(csb_n), .spi_sclk(sclk), .spi_sdi(sdi),
    .pri_level(p_lvl), .sec_level(s_lvl));

  // ==========================================================================
  // shared tasks
  task chk(input [23:0] g, input [23:0] e);
    checks = checks + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task rd(input [6:0] a, input [23:0] e);
    host.xfer(a, 1'b1, 24'h0, d);
    chk(d, e);
  endtask

  task wr(input [6:0] a, input [23:0] v);
    host.xfer(a, 1'b0, v, d);
  endtask

  // {o, oe_n, pullup, line level} of one pin for driver type and request
  task pin(input integer sel, input [1:0] ty, input rq);
    reg [3:0] g;
    reg [3:0] e;
    g = sel ? {s_o, s_oe_n, s_pu, s_lvl} : {p_o, p_oe_n, p_pu, p_lvl};
    e = {ty == 2'h1 && !rq, ty == 2'h0 || (!rq && ty != 2'h1), ty == 2'h3, !(rq && ty != 2'h0)};
    chk({20'h0, g}, {20'h0, e});
  endtask

  task beat;
    beat_event = 1'b1;
    @(negedge clk);
    beat_event = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // sample instants 20 cycles apart; seen notes any low level on the secondary line
  task tick(input integer k);
    seen = 0;
    repeat (k) begin
      sample_instant = 1'b1;
      @(negedge clk);
      sample_instant = 1'b0;
      repeat (19) begin
        @(negedge clk);
        if (s_lvl === 1'b0) begin
          seen = 1;
        end
      end
    end
  endtask

  task wrap_up;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task t_reset;
    pin(0, 2'h3, 1'b0);
    pin(1, 2'h3, 1'b0);
    rd(`IECM_ADDR_EN_PRI, 24'h000003);
    rd(`IECM_ADDR_EN_SEC, 24'h000003);
    rd(`IECM_ADDR_CLR_MGR, 24'h000004);
    rd(7'h7F, 24'h000000);
    wr(`IECM_ADDR_EN_PRI, 24'hFFFFFF);
    rd(`IECM_ADDR_EN_PRI, 24'hF00F03);
    wr(`IECM_ADDR_EN_PRI, 24'h000003);
  endtask

  task t_types;
    for (s = 0; s < 2; s = s + 1) begin
      for (t = 0; t < 4; t = t + 1) begin
        wr(s ? `IECM_ADDR_EN_SEC : `IECM_ADDR_EN_PRI, 24'h000400 | t[23:0]);
        beat;
        pin(s, t[1:0], 1'b1);
        rd(`IECM_ADDR_STATUS, 24'h000400);
        pin(s, t[1:0], 1'b0);
      end
      wr(s ? `IECM_ADDR_EN_SEC : `IECM_ADDR_EN_PRI, 24'h000003);
    end
  endtask

  task t_leadoff;
    wr(`IECM_ADDR_EN_PRI, 24'h100003);
    lead_off_cond = 1'b1;
    repeat (15) @(negedge clk);
    pin(0, 2'h3, 1'b0);
    repeat (10) @(negedge clk);
    pin(0, 2'h3, 1'b1);
    wr(`IECM_ADDR_EN_PRI, 24'h000003);
    pin(0, 2'h3, 1'b0);
    lead_off_cond = 1'b0;
    lead_on_cond = 1'b1;
    loop_unlocked = 1'b1;
    repeat (2) @(negedge clk);
    lead_on_cond = 1'b0;
    loop_unlocked = 1'b0;
    rd(`IECM_ADDR_STATUS, 24'h100900);
    wr(`IECM_ADDR_EN_PRI, 24'h100003);
    pin(0, 2'h3, 1'b0);
    wr(`IECM_ADDR_EN_PRI, 24'h000003);
  endtask

  task t_recovery;
    wr(`IECM_ADDR_EN_SEC, 24'h200003);
    for (t = 0; t < 2; t = t + 1) begin
      wr(`IECM_ADDR_CLR_MGR, t ? 24'h000044 : 24'h000004);
      recovery_engaged = 1'b1;
      repeat (3) @(negedge clk);
      pin(1, 2'h3, 1'b1);
      rd(`IECM_ADDR_STATUS, 24'h200000);
      pin(1, 2'h3, t == 0);
      recovery_engaged = 1'b0;
      repeat (3) @(negedge clk);
      pin(1, 2'h3, t == 0);
      recovery_engaged = 1'b1;
      repeat (3) @(negedge clk);
      pin(1, 2'h3, 1'b1);
      recovery_engaged = 1'b0;
      rd(`IECM_ADDR_STATUS, 24'h200000);
      pin(1, 2'h3, 1'b0);
    end
  endtask

  task t_tick;
    wr(`IECM_ADDR_EN_SEC, 24'h000203);
    for (t = 0; t < 4; t = t + 1) begin
      wr(`IECM_ADDR_CLR_MGR, 24'h000004 | t[23:0]);
      // two uncounted instants re-learn the 20-cycle period after the write gap
      tick(2);
      n = 24'h0;
      repeat (32) begin
        tick(1);
        n = n + seen;
      end
      chk(n, t == 3 ? 24'h2 : 24'h20 >> t);
      pin(1, 2'h3, 1'b0);
    end
    wr(`IECM_ADDR_CLR_MGR, 24'h000000);
    tick(1);
    pin(1, 2'h3, 1'b1);
    rd(`IECM_ADDR_STATUS, 24'h000200);
    pin(1, 2'h3, 1'b0);
  endtask

  task t_beat;
    wr(`IECM_ADDR_EN_SEC, 24'h000403);
    wr(`IECM_ADDR_CLR_MGR, 24'h000024);
    beat;
    tick(1);
    pin(1, 2'h3, 1'b1);
    tick(1);
    pin(1, 2'h3, 1'b0);
    wr(`IECM_ADDR_CLR_MGR, 24'h000014);
    beat;
    rd(`IECM_ADDR_STATUS, 24'h000400);
    pin(1, 2'h3, 1'b1);
    host.xfer(`IECM_ADDR_BEAT_IVL, 1'b1, 24'h0, d);
    pin(1, 2'h3, 1'b0);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_types;
    t_leadoff;
    t_recovery;
    t_tick;
    t_beat;
    sys_rst = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    wrap_up;
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_errors = n_errors + 1;
    $display("CHECK FAILED t=%0t run too long", $time);
    wrap_up;
  end
endmodule

// ==== src/iecm_consts.vh ====
`ifndef IECM_CONSTS_VH
`define IECM_CONSTS_VH

// ==========================================================================
// register addresses (7-bit spi address field)
`define IECM_ADDR_STATUS     7'h01
`define IECM_ADDR_EN_PRI     7'h02
`define IECM_ADDR_EN_SEC     7'h03
`define IECM_ADDR_CLR_MGR    7'h04
`define IECM_ADDR_BEAT_IVL   7'h25

// ==========================================================================
// field positions
`define IECM_BIT_RECOV       21
`define IECM_BIT_LOFF        20
`define IECM_BIT_LON         11
`define IECM_BIT_BEAT        10
`define IECM_BIT_TICK        9
`define IECM_BIT_UNLOCK      8
`define IECM_BIT_RECOV_CLR   6
`define IECM_BIT_BEAT_CLR_HI 5
`define IECM_BIT_BEAT_CLR_LO 4
`define IECM_BIT_TICK_CLR    2
`define IECM_BIT_RATE_HI     1
`define IECM_BIT_RATE_LO     0

// ==========================================================================
// writable bits and reset values
`define IECM_EN_MASK         24'hF00F03
`define IECM_MGR_MASK        24'h000077
`define IECM_EN_RST          24'h000003
`define IECM_MGR_RST         24'h000004

// ==========================================================================
// encodings
`define IECM_DRV_HIZ         2'h0
`define IECM_DRV_PUSH        2'h1
`define IECM_DRV_OD          2'h2
`define IECM_DRV_OD_PU       2'h3
`define IECM_BEAT_CLR_STAT   2'h0
`define IECM_BEAT_CLR_IVL    2'h1
`define IECM_BEAT_CLR_SELF   2'h2

// ==========================================================================
// timing
`define IECM_CLK_KHZ         20000
`define IECM_LOFF_MS         115
`define IECM_LOFF_CYC        (`IECM_LOFF_MS * `IECM_CLK_KHZ)
`define IECM_FRAME_BITS      6'h20
`define IECM_HDR_BITS        6'h08

`endif

// ==== src/iecm_core.v ====
`timescale 1ns/10ps
`include "iecm_consts.vh"

module iecm_core #(
  parameter [31:0] LOFF_CYC = `IECM_LOFF_CYC
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire spi_csb_n,
  input  wire spi_sclk,
  input  wire spi_sdi,
  output reg  spi_sdo_o,
  output reg  spi_sdo_oe_n,
  input  wire recovery_engaged,
  input  wire lead_off_cond,
  input  wire lead_on_cond,
  input  wire loop_unlocked,
  input  wire beat_event,
  input  wire sample_instant,
  output wire primary_irq_pin_o,
  output wire primary_irq_pin_oe_n,
  output wire primary_irq_pin_pullup_en,
  output wire secondary_irq_pin_o,
  output wire secondary_irq_pin_oe_n,
  output wire secondary_irq_pin_pullup_en
);

  localparam [21:0] LOFF_LIM = LOFF_CYC[21:0];
  localparam [2:0]  PIN_RST  = 3'h4;

  // ========================================================================
  // pin synchronisers: three stages, change taken when stages two and three agree
  wire [2:0] pin_raw;
  wire [2:0] pin_flt;

  assign pin_raw = {spi_csb_n, spi_sclk, spi_sdi};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg flt_q;
      always @(posedge clk) begin
        if (sys_rst) begin
          s1_q  <= PIN_RST[g];
          s2_q  <= PIN_RST[g];
          s3_q  <= PIN_RST[g];
          flt_q <= PIN_RST[g];
        end else begin
          s1_q <= pin_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            flt_q <= s3_q;
          end
        end
      end
      assign pin_flt[g] = flt_q;
    end
  endgenerate

  // ========================================================================
  // registers and flags
  reg  [23:0] en_pri_q;
  reg  [23:0] en_sec_q;
  reg  [23:0] mgr_q;
  reg         recov_q;
  reg         loff_q;
  reg         lon_q;
  reg         beat_q;
  reg         tick_q;
  reg         unlock_q;
  wire [5:0]  flags;
  wire [23:0] status_word;

  assign flags = {recov_q, loff_q, lon_q, beat_q, tick_q, unlock_q};
  assign status_word = {2'h0, recov_q, loff_q, 8'h00, lon_q, beat_q, tick_q, unlock_q, 8'h00};

  // enabled-flag overlap for one pin
  function irq_hit;
    input [23:0] en;
    input [5:0]  fl;
    begin
      irq_hit = |({en[23:20], en[11:8]} & {2'h0, fl});
    end
  endfunction

  // read data for an address
  function [23:0] rd_word;
    input [6:0]  addr;
    input [23:0] stat;
    input [23:0] e1;
    input [23:0] e2;
    input [23:0] mg;
    begin
      case (addr)
        `IECM_ADDR_STATUS:  rd_word = stat;
        `IECM_ADDR_EN_PRI:  rd_word = e1;
        `IECM_ADDR_EN_SEC:  rd_word = e2;
        `IECM_ADDR_CLR_MGR: rd_word = mg;
        default:            rd_word = 24'h000000;
      endcase
    end
  endfunction

  // ========================================================================
  // spi slave: 7 address bits, read bit, 24 data bits, msb first
  wire        csb_n;
  wire        sclk;
  wire        sdi;
  reg         sclk_d_q;
  reg  [5:0]  bit_q;
  reg  [31:0] shin_q;
  reg  [23:0] shout_q;
  reg  [6:0]  addr_q;
  reg         rd_q;
  wire        rise;
  wire        fall;
  wire        frame_end;
  wire [23:0] wdata;
  wire        status_read;
  wire        ivl_read;

  assign csb_n       = pin_flt[2];
  assign sclk        = pin_flt[1];
  assign sdi         = pin_flt[0];
  assign rise        = ~csb_n & sclk & ~sclk_d_q;
  assign fall        = ~csb_n & ~sclk & sclk_d_q;
  assign frame_end   = rise & (bit_q == (`IECM_FRAME_BITS - 6'h01));
  assign wdata       = {shin_q[22:0], sdi};
  assign status_read = frame_end & rd_q & (addr_q == `IECM_ADDR_STATUS);
  assign ivl_read    = frame_end & rd_q & (addr_q == `IECM_ADDR_BEAT_IVL);

  always @(posedge clk) begin
    if (sys_rst) begin
      sclk_d_q     <= 1'b0;
      bit_q        <= 6'h00;
      shin_q       <= 32'h00000000;
      shout_q      <= 24'h000000;
      addr_q       <= 7'h00;
      rd_q         <= 1'b0;
      spi_sdo_o    <= 1'b0;
      spi_sdo_oe_n <= 1'b1;
    end else begin
      sclk_d_q <= sclk;
      if (csb_n) begin
        bit_q        <= 6'h00;
        rd_q         <= 1'b0;
        spi_sdo_oe_n <= 1'b1;
      end else begin
        if (rise && bit_q != `IECM_FRAME_BITS) begin
          shin_q <= {shin_q[30:0], sdi};
          bit_q  <= bit_q + 6'h01;
          if (bit_q == (`IECM_HDR_BITS - 6'h01)) begin
            addr_q  <= shin_q[6:0];
            rd_q    <= sdi;
            shout_q <= rd_word(shin_q[6:0], status_word, en_pri_q, en_sec_q, mgr_q);
          end
        end
        if (fall && rd_q && bit_q >= `IECM_HDR_BITS && bit_q != `IECM_FRAME_BITS) begin
          spi_sdo_o    <= shout_q[23];
          spi_sdo_oe_n <= 1'b0;
          shout_q      <= {shout_q[22:0], 1'b0};
        end
      end
    end
  end

  // ========================================================================
  // register writes at the 32nd clock edge
  always @(posedge clk) begin
    if (sys_rst) begin
      en_pri_q <= `IECM_EN_RST;
      en_sec_q <= `IECM_EN_RST;
      mgr_q    <= `IECM_MGR_RST;
    end else if (frame_end && !rd_q) begin
      case (addr_q)
        `IECM_ADDR_EN_PRI:  en_pri_q <= wdata & `IECM_EN_MASK;
        `IECM_ADDR_EN_SEC:  en_sec_q <= wdata & `IECM_EN_MASK;
        `IECM_ADDR_CLR_MGR: mgr_q    <= wdata & `IECM_MGR_MASK;
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // data-rate period measurement and tick divider
  reg  [23:0] per_cnt_q;
  reg  [23:0] per_q;
  reg  [3:0]  div_q;
  reg  [21:0] tick_age_q;
  wire [21:0] quarter;
  wire [21:0] quarter_min;
  wire [1:0]  rate;
  reg         rate_hit;
  wire        tick_set;

  assign quarter     = per_q[23:2];
  assign quarter_min = (quarter == 22'h000000) ? 22'h000001 : quarter;
  assign rate        = mgr_q[`IECM_BIT_RATE_HI:`IECM_BIT_RATE_LO];

  always @* begin
    case (rate)
      2'h0:    rate_hit = 1'b1;
      2'h1:    rate_hit = (div_q[0] == 1'b0);
      2'h2:    rate_hit = (div_q[1:0] == 2'h0);
      default: rate_hit = (div_q == 4'h0);
    endcase
  end

  assign tick_set = sample_instant & rate_hit;

  always @(posedge clk) begin
    if (sys_rst) begin
      per_cnt_q <= 24'h000000;
      per_q     <= 24'h000000;
      div_q     <= 4'h0;
    end else if (sample_instant) begin
      per_cnt_q <= 24'h000001;
      per_q     <= per_cnt_q;
      div_q     <= div_q + 4'h1;
    end else if (per_cnt_q != 24'hFFFFFF) begin
      per_cnt_q <= per_cnt_q + 24'h000001;
    end
  end

  // ========================================================================
  // lead-off qualification timer
  reg [21:0] loff_cnt_q;
  wire       loff_qual;

  assign loff_qual = lead_off_cond & (loff_cnt_q == LOFF_LIM);

  always @(posedge clk) begin
    if (sys_rst || !lead_off_cond) begin
      loff_cnt_q <= 22'h000000;
    end else if (loff_cnt_q != LOFF_LIM) begin
      loff_cnt_q <= loff_cnt_q + 22'h000001;
    end
  end

  // ========================================================================
  // status flags; a set in the same cycle as a clear wins
  reg        recov_d_q;
  reg        beat_arm_q;
  wire [1:0] beat_mode;
  wire       recov_rise;
  wire       beat_clr;
  wire       tick_clr;

  assign beat_mode  = mgr_q[`IECM_BIT_BEAT_CLR_HI:`IECM_BIT_BEAT_CLR_LO];
  assign recov_rise = recovery_engaged & ~recov_d_q;
  assign beat_clr   = (beat_mode == `IECM_BEAT_CLR_IVL)  ? ivl_read :
                      (beat_mode == `IECM_BEAT_CLR_SELF) ? (sample_instant & beat_arm_q) :
                      status_read;
  assign tick_clr   = mgr_q[`IECM_BIT_TICK_CLR] ? (tick_age_q >= quarter_min) :
                      status_read;

  always @(posedge clk) begin
    if (sys_rst) begin
      recov_d_q  <= 1'b0;
      recov_q    <= 1'b0;
      loff_q     <= 1'b0;
      lon_q      <= 1'b0;
      beat_q     <= 1'b0;
      beat_arm_q <= 1'b0;
      tick_q     <= 1'b0;
      tick_age_q <= 22'h000000;
      unlock_q   <= 1'b0;
    end else begin
      recov_d_q <= recovery_engaged;
      if (mgr_q[`IECM_BIT_RECOV_CLR]) begin
        recov_q <= recov_rise | (recov_q & ~status_read);
      end else begin
        recov_q <= recovery_engaged | (recov_q & ~status_read);
      end
      loff_q   <= loff_qual | (loff_q & ~status_read);
      lon_q    <= lead_on_cond | (lon_q & ~status_read);
      unlock_q <= loop_unlocked | (unlock_q & ~status_read);
      beat_q   <= beat_event | (beat_q & ~beat_clr);
      if (beat_event) begin
        beat_arm_q <= 1'b0;
      end else if (beat_q && sample_instant) begin
        beat_arm_q <= ~beat_arm_q;
      end
      tick_q <= tick_set | (tick_q & ~tick_clr);
      if (tick_set || !tick_q) begin
        tick_age_q <= 22'h000000;
      end else begin
        tick_age_q <= tick_age_q + 22'h000001;
      end
    end
  end

  // ========================================================================
  // interrupt pin drivers
  iecm_pin_drv u_pri (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .drv_type  (en_pri_q[1:0]),
    .irq_req   (irq_hit(en_pri_q, flags)),
    .pin_o     (primary_irq_pin_o),
    .pin_oe_n  (primary_irq_pin_oe_n),
    .pullup_en (primary_irq_pin_pullup_en)
  );

  iecm_pin_drv u_sec (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .drv_type  (en_sec_q[1:0]),
    .irq_req   (irq_hit(en_sec_q, flags)),
    .pin_o     (secondary_irq_pin_o),
    .pin_oe_n  (secondary_irq_pin_oe_n),
    .pullup_en (secondary_irq_pin_pullup_en)
  );

endmodule

// ==== src/iecm_pin_drv.v ====
`timescale 1ns/10ps
`include "iecm_consts.vh"

// ==========================================================================
// active-low interrupt pin driver with selectable driver type
module iecm_pin_drv (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [1:0] drv_type,
  input  wire       irq_req,
  output reg        pin_o,
  output reg        pin_oe_n,
  output reg        pullup_en
);

  always @(posedge clk) begin
    if (sys_rst) begin
      pin_o     <= 1'b0;
      pin_oe_n  <= 1'b1;
      pullup_en <= 1'b1;
    end else begin
      pullup_en <= (drv_type == `IECM_DRV_OD_PU);
      case (drv_type)
        `IECM_DRV_PUSH: begin
          pin_o    <= ~irq_req;
          pin_oe_n <= 1'b0;
        end
        `IECM_DRV_OD, `IECM_DRV_OD_PU: begin
          pin_o    <= 1'b0;
          pin_oe_n <= ~irq_req;
        end
        default: begin
          pin_o    <= 1'b0;
          pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

endmodule
